/* core/wdtc_ctrl.sv */
// watchdog timer with timed-access protected control register
`timescale 1ns/10ps
`include "wdtc_defs.svh"
module wdtc_ctrl #(
  parameter int TO_EXP0   = `WDTC_TO_EXP0,
  parameter int TO_EXP1   = `WDTC_TO_EXP1,
  parameter int TO_EXP2   = `WDTC_TO_EXP2,
  parameter int TO_EXP3   = `WDTC_TO_EXP3,
  parameter int RST_DELAY = `WDTC_RST_DELAY,
  parameter int MC_CLKS   = `WDTC_MC_CLKS
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire wdtc_pkg::wdtc_sfr_req_t sfr_req,
  output logic [7:0]                  sfr_rdata,
  input  wire wdtc_pkg::wdtc_rst_src_t rst_src,
  output logic                        wdt_irq,
  output logic                        wdt_rst
);

  localparam logic [`WDTC_CNT_W-1:0] LIM0 = `WDTC_CNT_W'((64'h1 << TO_EXP0) - 64'h1);
  localparam logic [`WDTC_CNT_W-1:0] LIM1 = `WDTC_CNT_W'((64'h1 << TO_EXP1) - 64'h1);
  localparam logic [`WDTC_CNT_W-1:0] LIM2 = `WDTC_CNT_W'((64'h1 << TO_EXP2) - 64'h1);
  localparam logic [`WDTC_CNT_W-1:0] LIM3 = `WDTC_CNT_W'((64'h1 << TO_EXP3) - 64'h1);
  localparam logic [`WDTC_POST_W-1:0] POST_LAST = `WDTC_POST_W'(RST_DELAY - 1);
  localparam logic [`WDTC_HOLD_W-1:0] HOLD_LAST = `WDTC_HOLD_W'(2 * MC_CLKS - 1);
  localparam logic [`WDTC_WIN_W-1:0]  WIN_INIT  = `WDTC_WIN_W'(`WDTC_UNLOCK_WIN);

  localparam wdtc_pkg::wdtc_state_t RST_S = '{
    unl:     wdtc_pkg::WDTC_TA_IDLE,
    default: '0
  };

  wdtc_pkg::wdtc_state_t    s_ff;
  wdtc_pkg::wdtc_state_t    nxt_s;
  logic [`WDTC_CNT_W-1:0]   lim;
  logic                     unl_wr;
  logic                     ctl_wr;
  logic                     xie_wr;
  logic                     open;
  logic                     clr_req;
  logic                     tmo;
  logic                     fire;
  logic [7:0]               rd_val;

  always_comb begin
    unique case (s_ff.sel)
      2'h0: lim = LIM0;
      2'h1: lim = LIM1;
      2'h2: lim = LIM2;
      2'h3: lim = LIM3;
    endcase
  end

  always_comb begin
    nxt_s   = s_ff;
    unl_wr  = sfr_req.we && (sfr_req.addr == `WDTC_ADDR_UNLOCK);
    ctl_wr  = sfr_req.we && (sfr_req.addr == `WDTC_ADDR_CTRL);
    xie_wr  = sfr_req.we && (sfr_req.addr == `WDTC_ADDR_XIE);
    open    = (s_ff.unl == wdtc_pkg::WDTC_TA_OPEN);
    clr_req = ctl_wr && open && sfr_req.wdata[`WDTC_B_CLR];
    tmo     = s_ff.run && (s_ff.cnt == lim);
    fire    = 1'b0;
    rd_val  = 8'h00;

    // unlock sequence: the two keys must be back-to-back register writes
    unique case (s_ff.unl)
      wdtc_pkg::WDTC_TA_IDLE: begin
        if (unl_wr && sfr_req.wdata == `WDTC_KEY_FIRST) begin
          nxt_s.unl = wdtc_pkg::WDTC_TA_FIRST;
        end
      end
      wdtc_pkg::WDTC_TA_FIRST: begin
        if (unl_wr && sfr_req.wdata == `WDTC_KEY_SECOND) begin
          nxt_s.unl = wdtc_pkg::WDTC_TA_OPEN;
          nxt_s.win = WIN_INIT;
        end else if (unl_wr && sfr_req.wdata == `WDTC_KEY_FIRST) begin
          nxt_s.unl = wdtc_pkg::WDTC_TA_FIRST;
        end else if (sfr_req.we) begin
          nxt_s.unl = wdtc_pkg::WDTC_TA_IDLE;
        end
      end
      wdtc_pkg::WDTC_TA_OPEN: begin
        // one protected write per unlock; an idle window lapses
        if (unl_wr && sfr_req.wdata == `WDTC_KEY_FIRST) begin
          nxt_s.unl = wdtc_pkg::WDTC_TA_FIRST;
        end else if (sfr_req.we || s_ff.win == `WDTC_WIN_W'(1)) begin
          nxt_s.unl = wdtc_pkg::WDTC_TA_IDLE;
        end else begin
          nxt_s.win = s_ff.win - `WDTC_WIN_W'(1);
        end
      end
      default: nxt_s.unl = wdtc_pkg::WDTC_TA_IDLE;
    endcase

    // counter advances while run is set, restarted by time-out or clear
    if (clr_req) begin
      nxt_s.cnt      = '0;
      nxt_s.post     = 1'b0;
      nxt_s.post_cnt = '0;
    end else begin
      if (s_ff.post) begin
        if (s_ff.post_cnt == POST_LAST) begin
          nxt_s.post = 1'b0;
          fire       = s_ff.watchdog_reset_enable;
        end else begin
          nxt_s.post_cnt = s_ff.post_cnt + `WDTC_POST_W'(1);
        end
      end
      if (tmo) begin
        nxt_s.cnt      = '0;
        nxt_s.post     = 1'b1;
        nxt_s.post_cnt = '0;
      end else if (s_ff.run) begin
        nxt_s.cnt = s_ff.cnt + `WDTC_CNT_W'(1);
      end
    end

    // software writes
    if (ctl_wr) begin
      nxt_s.sel = sfr_req.wdata[`WDTC_B_SEL_HI:`WDTC_B_SEL_LO];
      if (!sfr_req.wdata[`WDTC_B_RF]) begin
        nxt_s.watchdog_reset_flag = 1'b0;
      end
      if (open) begin
        nxt_s.run   = sfr_req.wdata[`WDTC_B_RUN];
        nxt_s.watchdog_reset_enable = sfr_req.wdata[`WDTC_B_RE];
        nxt_s.watchdog_interrupt_flag  = sfr_req.wdata[`WDTC_B_IF];
      end
    end
    if (xie_wr) begin
      nxt_s.xie = sfr_req.wdata[`WDTC_B_XIE_HI:`WDTC_B_XIE_WDI];
    end
    // a time-out in the same cycle as a clearing write still sets the flag
    if (tmo && s_ff.xie[0]) begin
      nxt_s.watchdog_interrupt_flag = 1'b1;
    end

    // registered read port; unmapped and write-only addresses read zero
    if (sfr_req.addr == `WDTC_ADDR_CTRL) begin
      rd_val[`WDTC_B_RUN]    = s_ff.run;
      rd_val[`WDTC_B_SEL_HI] = s_ff.sel[1];
      rd_val[`WDTC_B_SEL_LO] = s_ff.sel[0];
      rd_val[`WDTC_B_IF]     = s_ff.watchdog_interrupt_flag;
      rd_val[`WDTC_B_RF]     = s_ff.watchdog_reset_flag;
      rd_val[`WDTC_B_RE]     = s_ff.watchdog_reset_enable;
    end else if (sfr_req.addr == `WDTC_ADDR_XIE) begin
      rd_val[`WDTC_B_XIE_HI:`WDTC_B_XIE_WDI] = s_ff.xie;
    end
    if (sfr_req.re) begin
      nxt_s.rdata = rd_val;
    end

    // watchdog reset: held for two machine cycles, flag set
    if (s_ff.hold) begin
      nxt_s          = RST_S;
      nxt_s.watchdog_reset_flag     = 1'b1;
      nxt_s.hold     = (s_ff.hold_cnt != '0);
      nxt_s.hold_cnt = s_ff.hold_cnt - `WDTC_HOLD_W'(s_ff.hold_cnt != '0);
    end else if (fire) begin
      nxt_s          = RST_S;
      nxt_s.watchdog_reset_flag     = 1'b1;
      nxt_s.hold     = 1'b1;
      nxt_s.hold_cnt = HOLD_LAST;
    end
    if (rst_src.ext_rst) begin
      nxt_s      = RST_S;
      nxt_s.watchdog_reset_flag = s_ff.watchdog_reset_flag;
    end
    if (rst_src.pwr_rst) begin
      nxt_s = RST_S;
    end
  end

  // power-on reset is the asynchronous pin; all state returns to zero except the unlock state, which returns to idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= RST_S;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sfr_rdata = s_ff.rdata;
  assign wdt_irq   = s_ff.watchdog_interrupt_flag && s_ff.xie[0];
  assign wdt_rst   = s_ff.hold;

endmodule // wdtc_ctrl

/* core/wdtc_defs.svh */
// constants of the watchdog timer control block
//
// Contract
// - select code 00/01/10/11 gives 2^17, 2^20, 2^23, 2^26 clock interrupt time-out.
// - reset time-out is always 512 clocks longer than the interrupt time-out.
// - at time-out request interrupt if enabled; reset 512 clocks later unless cleared.
// - interrupt flag set by hardware at enabled time-out, held until software clears.
// - a watchdog reset sets the reset flag; software reads and clears it.
// - power-fail, power-on and power-down resets clear the reset flag.
// - an external pin reset leaves the reset flag unchanged.
// - reset enable bit 0 disables and 1 enables the watchdog reset.
// - every reset source forces the reset enable bit to zero.
// - writing 1 to the clear bit restarts the counter from zero.
// - power-on reset loads the whole control register with zero.
// - all bits readable (the code reads the clear bit as zero); run, reset enable, flag, clear writes need the unlock.
// - bit 4 of the extended enable register gates the watchdog interrupt.
// - a watchdog reset is held two machine cycles, then the reset flag set; the code sets the flag as the hold begins.
`ifndef WDTC_DEFS_SVH
`define WDTC_DEFS_SVH

`define WDTC_ADDR_UNLOCK 8'hC7
`define WDTC_ADDR_CTRL   8'hD8
`define WDTC_ADDR_XIE    8'hE8

`define WDTC_KEY_FIRST   8'hAA
`define WDTC_KEY_SECOND  8'h55

`define WDTC_B_RUN       7
`define WDTC_B_SEL_HI    5
`define WDTC_B_SEL_LO    4
`define WDTC_B_IF        3
`define WDTC_B_RF        2
`define WDTC_B_RE        1
`define WDTC_B_CLR       0
`define WDTC_B_XIE_WDI   4
`define WDTC_B_XIE_HI    6

`define WDTC_CNT_W       26
`define WDTC_POST_W      10
`define WDTC_HOLD_W      8
`define WDTC_WIN_W       4

`define WDTC_TO_EXP0     17
`define WDTC_TO_EXP1     20
`define WDTC_TO_EXP2     23
`define WDTC_TO_EXP3     26
`define WDTC_RST_DELAY   512
`define WDTC_UNLOCK_WIN  4
`define WDTC_MC_CLKS     4

`endif

/* core/wdtc_pkg.sv */
// types of the watchdog timer control block
`include "wdtc_defs.svh"
package wdtc_pkg;

  typedef enum logic [2:0] {
    WDTC_TA_IDLE  = 3'h1,
    WDTC_TA_FIRST = 3'h2,
    WDTC_TA_OPEN  = 3'h4
  } wdtc_unlock_t;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wdtc_sfr_req_t;

  typedef struct packed {
    logic pwr_rst;
    logic ext_rst;
  } wdtc_rst_src_t;

  typedef struct packed {
    wdtc_unlock_t            unl;
    logic [`WDTC_WIN_W-1:0]  win;
    logic [`WDTC_CNT_W-1:0]  cnt;
    logic                    post;
    logic [`WDTC_POST_W-1:0] post_cnt;
    logic                    hold;
    logic [`WDTC_HOLD_W-1:0] hold_cnt;
    logic                    run;
    logic [1:0]              sel;
    logic                    watchdog_interrupt_flag;
    logic                    watchdog_reset_flag;
    logic                    watchdog_reset_enable;
    logic [2:0]              xie;
    logic [7:0]              rdata;
  } wdtc_state_t;

endpackage

/* dv/wdtc_ctrl_props.sv */
// assertion checker for the watchdog timer control block
`timescale 1ns/10ps
module wdtc_ctrl_props #(
  parameter int MC_CLKS = 4
) (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire wdtc_pkg::wdtc_sfr_req_t sfr_req,
  input wire logic [7:0]              sfr_rdata,
  input wire wdtc_pkg::wdtc_rst_src_t rst_src,
  input wire logic                    wdt_irq,
  input wire logic                    wdt_rst
);
  int  hold_ff;
  wire rd_ok = sfr_req.re && !rst_src.pwr_rst && !rst_src.ext_rst;

  // counts how long the reset pulse has stood so far
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hold_ff <= 0;
    else hold_ff <= wdt_rst ? hold_ff + 1 : 0;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_hold_len: assert property ($fell(wdt_rst) |-> hold_ff == 2 * MC_CLKS)
    else $error("reset pulse length wrong");
  a_hold_no_irq: assert property (wdt_rst |-> ##1 !wdt_irq)
    else $error("interrupt during reset");
  a_pwr_clear: assert property (rst_src.pwr_rst |=> sfr_rdata == 8'h00 && !wdt_irq && !wdt_rst)
    else $error("power reset left state");
  a_ext_clear: assert property (rst_src.ext_rst |=> !wdt_irq && !wdt_rst)
    else $error("pin reset left outputs");
  a_unlock_reads_zero: assert property (rd_ok && sfr_req.addr == 8'hC7 |=> sfr_rdata == 8'h00)
    else $error("unlock register read not zero");
  a_ctrl_fixed_zero: assert property (rd_ok && sfr_req.addr == 8'hD8 |=> !sfr_rdata[6] && !sfr_rdata[0])
    else $error("control fixed bits not zero");
  a_xie_mask_ok: assert property (rd_ok && sfr_req.addr == 8'hE8 |=> (sfr_rdata & 8'h8F) == 8'h00)
    else $error("enable register spare bits set");
  a_rdata_stands: assert property (!sfr_req.re && rst_src == '0 |=> $stable(sfr_rdata) || wdt_rst)
    else $error("read data changed without read");
  a_quiet_after_por: assert property ($rose(rst_n) |-> !wdt_rst [*8])
    else $error("reset right after power-on");

  c_irq: cover property ($rose(wdt_irq));
  c_rst: cover property ($rose(wdt_rst));
  c_ext: cover property (rst_src.ext_rst);
endmodule // wdtc_ctrl_props

bind wdtc_ctrl wdtc_ctrl_props #(.MC_CLKS(MC_CLKS)) i_wdtc_ctrl_props (.clk(clk), .rst_n(rst_n),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .rst_src(rst_src), .wdt_irq(wdt_irq),
  .wdt_rst(wdt_rst));

/* dv/testbench.sv */
// self-checking bench for the watchdog timer control block
`timescale 1ns/10ps
module testbench;
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  wdtc_pkg::wdtc_sfr_req_t req = '0;
  wdtc_pkg::wdtc_rst_src_t src = '0;
  logic [7:0]              rdata;
  logic                    irq;
  logic                    wrst;
  int                      num_errors = 0;
  int                      checks_done = 0;
  int                      n;

  always #12.5 clk = ~clk;

  // short counts keep the run brief: limits 2^4..2^7, reset delay 8
  wdtc_ctrl #(.TO_EXP0(4), .TO_EXP1(5), .TO_EXP2(6), .TO_EXP3(7), .RST_DELAY(8))
    i_wdtc_ctrl (.clk(clk), .rst_n(rst_n), .sfr_req(req), .sfr_rdata(rdata), .rst_src(src),
    .wdt_irq(irq), .wdt_rst(wrst));

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic fail(input string m);
    num_errors++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) fail($sformatf("got %h exp %h", g, e));
  endtask

  task automatic chk_rng(input int v, input int lo, input int hi);
    checks_done++;
    if (v < lo || v > hi) fail($sformatf("count %0d", v));
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    #1;
    chk(rdata, e);
  endtask

  task automatic unlock();
    wr(8'hC7, 8'hAA);
    wr(8'hC7, 8'h55);
  endtask

  // w selects the reset output, else the interrupt
  task automatic wait_on(input bit w, input int lim);
    n = 0;
    while ((w ? wrst : irq) !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim) begin
        fail("wait ran out");
        test_done();
      end
    end
  endtask

  task automatic s_regs();
    rd(8'hD8, 8'h00);
    rd(8'hC7, 8'h00);
    rd(8'h42, 8'h00);
    wr(8'hE8, 8'hFF);
    rd(8'hE8, 8'h70);
    wr(8'hD8, 8'hFF);
    rd(8'hD8, 8'h30);
    // select bits written as before, so only a leaked run bit would change the read
    unlock();
    wr(8'hE8, 8'h10);
    wr(8'hD8, 8'hB0);
    rd(8'hD8, 8'h30);
    unlock();
    repeat (6) @(posedge clk);
    wr(8'hD8, 8'hB0);
    rd(8'hD8, 8'h30);
  endtask

  task automatic s_timeout();
    for (int s = 0; s < 4; s++) begin
      unlock();
      wr(8'hD8, {2'b10, s[1:0], 4'h0});
      wait_on(1'b0, 200);
      chk_rng(n, (1 << (4 + s)) - 2, (1 << (4 + s)) + 2);
      repeat (4) @(posedge clk);
      #1;
      chk({7'h00, irq}, 8'h01);
      unlock();
      wr(8'hD8, {2'b00, s[1:0], 4'h1});
      rd(8'hD8, {2'b00, s[1:0], 4'h0});
    end
    wr(8'hE8, 8'h00);
    unlock();
    wr(8'hD8, 8'h80);
    repeat (20) @(posedge clk);
    rd(8'hD8, 8'h80);
    unlock();
    wr(8'hD8, 8'h01);
  endtask

  task automatic s_reset();
    wr(8'hE8, 8'h10);
    repeat (4) begin
      unlock();
      wr(8'hD8, 8'h83);
      repeat (6) @(posedge clk);
    end
    #1;
    chk({6'h00, irq, wrst}, 8'h00);
    wait_on(1'b0, 40);
    wait_on(1'b1, 20);
    chk_rng(n, 8, 10);
    repeat (10) @(posedge clk);
    rd(8'hD8, 8'h04);
    // reset enable set again so that each reset source has something to clear
    unlock();
    wr(8'hD8, 8'h06);
    rd(8'hD8, 8'h06);
    @(posedge clk);
    src <= '{pwr_rst: 1'b0, ext_rst: 1'b1};
    @(posedge clk);
    src <= '0;
    rd(8'hD8, 8'h04);
    unlock();
    wr(8'hD8, 8'h06);
    @(posedge clk);
    src <= '{pwr_rst: 1'b1, ext_rst: 1'b0};
    @(posedge clk);
    src <= '0;
    rd(8'hD8, 8'h00);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    s_regs();
    s_timeout();
    s_reset();
    test_done();
  end
endmodule // testbench
